// ### verilog/pbmc_map.svh
// Purpose: offsets, field positions, reset values and timing figures of the
//          basic mode control block (low half, bits 11 down to 0)
// Assumes: a 16-bit management register at management address 0x00
// Notes:   included by bare name; definitions only
`ifndef PBMC_MAP_SVH
`define PBMC_MAP_SVH

`define PBMC_ADDR_W          5
`define PBMC_DATA_W          16
`define PBMC_BMC_OFFSET      5'h00

`define PBMC_POS_AN_ENABLE   12
`define PBMC_POS_POWER_DOWN  11
`define PBMC_POS_ISOLATE     10
`define PBMC_POS_RESTART     9
`define PBMC_POS_DUPLEX      8
`define PBMC_POS_COL_TEST    7

`define PBMC_RST_POWER_DOWN  1'h0
`define PBMC_RST_ISOLATE     1'h0
`define PBMC_RST_RESTART     1'h0
`define PBMC_RST_COL_TEST    1'h0
`define PBMC_RST_DUPLEX      1'h0

`define PBMC_CLK_PERIOD_NS   25
`define PBMC_BIT_NS          10
`define PBMC_COL_ON_BITS     512
`define PBMC_COL_OFF_BITS    4

`endif

// ### verilog/pbmc_pkg.sv
// Purpose: types shared by the basic mode control block
// Assumes: constants live in pbmc_map.svh
// Notes:   struct fields are the writable control bits and the MII carriers
package pbmc_pkg;

  // writable control bits of the low half
  typedef struct packed {
    logic power_down;
    logic isolate;
    logic restart;
    logic duplex;
    logic col_test;
  } pbmc_ctrl_type;

  // receive-side MII signals, core to pins
  typedef struct packed {
    logic       rx_dv;
    logic [3:0] rxd;
    logic       rx_er;
    logic       crs;
    logic       col;
  } pbmc_mii_rx_type;

  // transmit-side MII signals, pins to core
  typedef struct packed {
    logic       tx_en;
    logic [3:0] txd;
    logic       tx_er;
  } pbmc_mii_tx_type;

  // restart handshake with the negotiation engine
  typedef enum logic [1:0] {
    PBMC_AN_IDLE = 2'b01,
    PBMC_AN_REQ  = 2'b10
  } pbmc_an_state_type;

endpackage

// ### verilog/pbmc_sync.sv
// Purpose: two flip-flop synchroniser for pin-level inputs
// Assumes: inputs are asynchronous levels, not pulses
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
module pbmc_sync #(
  parameter int          WIDTH     = 1,
  parameter logic [15:0] RST_VALUE = 16'h0000
) (
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // plain two-stage chain, reset to a constant idle level
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= RST_VALUE[WIDTH-1:0];
      sync_q <= RST_VALUE[WIDTH-1:0];
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// ### verilog/pbmc_top.sv
// Purpose: low half of the basic mode control register and the logic it steers
// Assumes: a management frame decoder presents one-cycle read/write strobes;
//          auto-negotiation enable (bit 12) is held by the upper-half logic
// Notes:   MII pins are split into value and output enable; no tristate here
//          the pad ring turns mii_rx_oe_o into the float, so the core keeps
//          a single driver on every net and never carries a floating value
//          the MAC transmit pins share no clock with ref_clk_i, so they pass
//          the same two-stage chain as the power-down pin
//          collision release meets its bit-time budget at 10 Mb/s only
`timescale 1ns/10ps
`include "pbmc_map.svh"
module pbmc_top (
  input  wire logic                      ref_clk_i,
  input  wire logic                      resetn_i,
  // management register port
  input  wire logic [`PBMC_ADDR_W-1:0]   mgmt_addr_i,
  input  wire logic                      mgmt_wr_i,
  input  wire logic                      mgmt_rd_i,
  input  wire logic [`PBMC_DATA_W-1:0]   mgmt_wdata_i,
  output logic      [`PBMC_DATA_W-1:0]   mgmt_rdata_o,
  output logic                           mgmt_rvalid_o,
  // neighbouring logic
  input  wire logic                      an_enable_i,
  input  wire logic                      an_full_duplex_i,
  input  wire logic                      an_started_i,
  input  wire logic                      duplex_strap_i,
  input  wire logic                      power_down_interrupt_pin_n_i,
  output logic                           an_restart_o,
  output logic                           power_down_o,
  output logic                           func_enable_o,
  output logic                           full_duplex_o,
  // MII facing the MAC
  input  wire pbmc_pkg::pbmc_mii_tx_type mii_tx_i,
  output pbmc_pkg::pbmc_mii_rx_type      mii_rx_o,
  output logic                           mii_rx_oe_o,
  // core side of the MII
  input  wire pbmc_pkg::pbmc_mii_rx_type core_rx_i,
  output pbmc_pkg::pbmc_mii_tx_type      core_tx_o
);
  import pbmc_pkg::*;

  localparam int PD_W = 1;
  localparam int TX_W = $bits(pbmc_mii_tx_type);

  // bit-time budgets for the collision echo, in clock cycles
  // kept beside the logic so a faster clock or a shorter chain can be
  // judged against them; the echo path itself is a fixed three edges
  localparam int COL_ON_NS   = `PBMC_COL_ON_BITS * `PBMC_BIT_NS;
  localparam int COL_OFF_NS  = `PBMC_COL_OFF_BITS * `PBMC_BIT_NS;
  localparam int COL_ON_CYC  = (COL_ON_NS / `PBMC_CLK_PERIOD_NS < 1) ? 1
                             : COL_ON_NS / `PBMC_CLK_PERIOD_NS;
  localparam int COL_OFF_CYC = (COL_OFF_NS / `PBMC_CLK_PERIOD_NS < 1) ? 1
                             : COL_OFF_NS / `PBMC_CLK_PERIOD_NS;

  // decode helper used by both read and write paths
  function automatic logic hit(input logic [`PBMC_ADDR_W-1:0] addr);
    hit = (addr == `PBMC_BMC_OFFSET);
  endfunction

  // readback word from the stored bits; reserved and upper bits stay zero
  // upper half (15:12) is answered by its own logic, so zero here is safe
  function automatic logic [`PBMC_DATA_W-1:0] pack_ctrl(input pbmc_ctrl_type c);
    pack_ctrl                       = '0;
    pack_ctrl[`PBMC_POS_POWER_DOWN] = c.power_down;
    pack_ctrl[`PBMC_POS_ISOLATE]    = c.isolate;
    pack_ctrl[`PBMC_POS_RESTART]    = c.restart;
    pack_ctrl[`PBMC_POS_DUPLEX]     = c.duplex;
    pack_ctrl[`PBMC_POS_COL_TEST]   = c.col_test;
  endfunction

  // pin inputs through two flip-flops
  // both chains reset to the idle level of their pins: the power-down
  // pin idles high, so leaving reset never fakes a power-down request
  // the transmit bits are synced one by one; a word that changes in the
  // sampling window may land split over two cycles, which the echo
  // tolerates since it only looks at tx_en
  logic            pd_pin_n_s;
  pbmc_mii_tx_type tx_s;

  pbmc_sync #(
    .WIDTH     (PD_W),
    .RST_VALUE (16'h0001)
  ) u_pd_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .async_i   (power_down_interrupt_pin_n_i),
    .sync_o    (pd_pin_n_s)
  );

  pbmc_sync #(
    .WIDTH     (TX_W),
    .RST_VALUE (16'h0000)
  ) u_tx_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .async_i   (mii_tx_i),
    .sync_o    (tx_s)
  );

  // control register state
  // the restart readback bit and the engine request are kept apart on
  // purpose: software may clear the first without touching the second
  pbmc_ctrl_type     ctrl_q;
  pbmc_ctrl_type     ctrl_d;
  logic              strap_done_q;
  logic              strap_done_d;
  pbmc_an_state_type an_q;
  pbmc_an_state_type an_d;
  logic              wr_hit;
  logic              restart_req;

  assign wr_hit      = mgmt_wr_i && hit(mgmt_addr_i);
  // a one only counts while negotiation is enabled
  assign restart_req = wr_hit && mgmt_wdata_i[`PBMC_POS_RESTART] && an_enable_i;

  // next values of the control bits
  // priority from low to high: strap, write, hardware clear, new request,
  // pin; later assignments win, so a new request or the pin beats any clear in one cycle
  always_comb begin
    ctrl_d       = ctrl_q;
    strap_done_d = 1'b1;
    // duplex strap caught on the first edge after reset release
    if (!strap_done_q) begin
      ctrl_d.duplex = duplex_strap_i;
    end
    if (wr_hit) begin
      ctrl_d.power_down = mgmt_wdata_i[`PBMC_POS_POWER_DOWN];
      ctrl_d.isolate    = mgmt_wdata_i[`PBMC_POS_ISOLATE];
      ctrl_d.duplex     = mgmt_wdata_i[`PBMC_POS_DUPLEX];
      ctrl_d.col_test   = mgmt_wdata_i[`PBMC_POS_COL_TEST];
      // zero clears only the readback, the engine request stays
      if (!mgmt_wdata_i[`PBMC_POS_RESTART]) begin
        ctrl_d.restart = 1'b0;
      end
    end
    // hardware clear once negotiation has begun
    if (an_started_i) begin
      ctrl_d.restart = 1'b0;
    end
    // a new request beats a clear in the same cycle
    if (restart_req) begin
      ctrl_d.restart = 1'b1;
    end
    // the pin forces the bit and wins over any write of zero
    if (!pd_pin_n_s) begin
      ctrl_d.power_down = 1'b1;
    end
  end

  // reset loads constants only; the strap is taken one edge later
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q.power_down <= `PBMC_RST_POWER_DOWN;
      ctrl_q.isolate    <= `PBMC_RST_ISOLATE;
      ctrl_q.restart    <= `PBMC_RST_RESTART;
      ctrl_q.duplex     <= `PBMC_RST_DUPLEX;
      ctrl_q.col_test   <= `PBMC_RST_COL_TEST;
      strap_done_q      <= 1'b0;
    end else begin
      ctrl_q       <= ctrl_d;
      strap_done_q <= strap_done_d;
    end
  end

  // restart handshake: request held to the engine until it starts,
  // independent of what software later writes to the readback bit
  // a started report and a fresh request in the same cycle keep the
  // request up, so a second restart is never lost
  always_comb begin
    an_d = an_q;
    unique case (an_q)
      PBMC_AN_IDLE: begin
        if (restart_req) begin
          an_d = PBMC_AN_REQ;
        end
      end
      PBMC_AN_REQ: begin
        if (an_started_i && !restart_req) begin
          an_d = PBMC_AN_IDLE;
        end
      end
      default: begin
        an_d = PBMC_AN_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      an_q <= PBMC_AN_IDLE;
    end else begin
      an_q <= an_d;
    end
  end

  assign an_restart_o = (an_q == PBMC_AN_REQ);

  // effective power down and function enable
  // the pin acts on the synced level straight away, one edge before
  // the stored bit follows; the register block is never gated
  logic pd_eff;
  assign pd_eff        = ctrl_q.power_down || !pd_pin_n_s;
  assign power_down_o  = pd_eff;
  assign func_enable_o = !pd_eff;

  // duplex resolution; manual bit only counts without negotiation
  // registered so a change of the enable never glitches the MAC side
  // limitation: the resolved value lags its inputs by one edge
  logic full_dx_d;
  logic full_dx_q;
  assign full_dx_d = an_enable_i ? an_full_duplex_i : ctrl_q.duplex;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      full_dx_q <= 1'b0;
    end else begin
      full_dx_q <= full_dx_d;
    end
  end

  assign full_duplex_o = full_dx_q;

  // MII path; isolation and power down both cut the port
  // while cut, values are forced to zero as well as the enable dropping,
  // so nothing stale reaches the MAC when the enable comes back
  // enable and values leave the same register stage, keeping them aligned
  logic            mii_live;
  pbmc_mii_rx_type rx_d;
  pbmc_mii_rx_type rx_q;
  logic            oe_q;
  pbmc_mii_tx_type ctx_d;
  pbmc_mii_tx_type ctx_q;

  assign mii_live = !ctrl_q.isolate && !pd_eff;

  // collision echo costs three edges from pin to pin, well inside
  // the 512-bit budget; the 4-bit release fits 10 Mb/s timing only
  always_comb begin
    rx_d  = mii_live ? core_rx_i : '0;
    ctx_d = mii_live ? tx_s : '0;
    if (mii_live && ctrl_q.col_test) begin
      rx_d.col = tx_s.tx_en;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_q  <= '0;
      oe_q  <= 1'b0;
      ctx_q <= '0;
    end else begin
      rx_q  <= rx_d;
      oe_q  <= mii_live;
      ctx_q <= ctx_d;
    end
  end

  assign mii_rx_o    = rx_q;
  assign mii_rx_oe_o = oe_q;
  assign core_tx_o   = ctx_q;

  // read path; reserved and foreign bits return zero
  // an unmapped read still answers, with zero data, so a frame decoder
  // never waits on a strobe that this block ignores
  logic [`PBMC_DATA_W-1:0] rdata_d;
  logic [`PBMC_DATA_W-1:0] rdata_q;
  logic                    rvalid_q;

  always_comb begin
    rdata_d = '0;
    if (mgmt_rd_i && hit(mgmt_addr_i)) begin
      rdata_d = pack_ctrl(ctrl_q);
    end
  end

  // registers stay reachable in power down
  // data is zero outside the answer cycle, so a wired-or of several
  // register blocks in the frame decoder needs no extra gating
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= mgmt_rd_i;
    end
  end

  assign mgmt_rdata_o  = rdata_q;
  assign mgmt_rvalid_o = rvalid_q;

endmodule

// ### testbench/pbmc_checker.sv
// Purpose: port assertions for pbmc_top
// Assumes: one clock, asynchronous active-low reset
// Notes:   col-test bit mirrored from management writes
`timescale 1ns/10ps
`include "pbmc_map.svh"
module pbmc_checker (
  input wire logic                      ref_clk_i,
  input wire logic                      resetn_i,
  input wire logic [`PBMC_ADDR_W-1:0]   mgmt_addr_i,
  input wire logic                      mgmt_wr_i,
  input wire logic [`PBMC_DATA_W-1:0]   mgmt_wdata_i,
  input wire logic                      an_enable_i,
  input wire logic                      an_full_duplex_i,
  input wire logic                      an_started_i,
  input wire logic                      power_down_interrupt_pin_n_i,
  input wire logic                      an_restart_o,
  input wire logic                      power_down_o,
  input wire logic                      full_duplex_o,
  input wire pbmc_pkg::pbmc_mii_tx_type mii_tx_i,
  input wire pbmc_pkg::pbmc_mii_rx_type mii_rx_o,
  input wire logic                      mii_rx_oe_o
);
  import pbmc_pkg::*;
  logic ct_q;
  logic ct_d;
  logic wr0;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // mirror of the col-test bit, needed because it leaves the block only through the readback
  assign wr0 = mgmt_wr_i && (mgmt_addr_i == `PBMC_BMC_OFFSET);
  always_comb ct_d = wr0 ? mgmt_wdata_i[`PBMC_POS_COL_TEST] : ct_q;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) ct_q <= 1'h0;
    else ct_q <= ct_d;
  end
  // pin low for three samples has passed both sync stages
  a_pin_forces_pd: assert property (!power_down_interrupt_pin_n_i [*3] |-> power_down_o)
    else $error("pin low did not power down");
  a_iso_cuts_mii: assert property (wr0 && mgmt_wdata_i[10] |-> ##2 !mii_rx_oe_o)
    else $error("isolate write left mii driven");
  a_cut_zeroes: assert property (!mii_rx_oe_o |-> mii_rx_o == 8'h00)
    else $error("mii outputs not zero while cut");
  a_restart_taken: assert property (wr0 && mgmt_wdata_i[9] && an_enable_i |=> an_restart_o)
    else $error("restart write not taken");
  a_restart_ignored: assert property (wr0 && !an_enable_i && !an_restart_o |=> !an_restart_o)
    else $error("restart taken with negotiation off");
  a_restart_holds: assert property (an_restart_o && !an_started_i |=> an_restart_o)
    else $error("restart request dropped early");
  a_duplex_auto: assert property (an_enable_i |=> full_duplex_o == $past(an_full_duplex_i))
    else $error("duplex not from negotiation");
  a_col_echo: assert property ((ct_q && mii_rx_oe_o) [*4] |-> mii_rx_o.col == $past(mii_tx_i.tx_en, 3))
    else $error("col does not echo tx_en");
  c_started: cover property (an_started_i);
  c_col: cover property (mii_rx_o.col);
  c_pin: cover property (!power_down_interrupt_pin_n_i [*3]);
endmodule

// ### testbench/pbmc_an_model.sv
// Purpose: negotiation engine model answering restart requests
// Assumes: delay_i of at least 1 cycle
// Notes:   one-cycle started pulse; no new start while pulsing
`timescale 1ns/10ps
module pbmc_an_model (
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       an_restart_i,
  input  wire logic [3:0] delay_i,
  output logic            an_started_o
);
  logic [3:0] cnt_q;
  // count down from the request, then report start once
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= 4'h0;
      an_started_o <= 1'h0;
    end else begin
      if (an_restart_i && cnt_q == 4'h0 && !an_started_o) cnt_q <= delay_i;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
      an_started_o <= (cnt_q == 4'h1);
    end
  end
endmodule

// ### testbench/tb_top.sv
// Purpose: self-checking bench for pbmc_top
// Assumes: duplex strap tied high; engine model answers restarts
// Notes:   m holds the expected low half of the register
`timescale 1ns/10ps
`include "pbmc_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import pbmc_pkg::*;
  logic            clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, rv, fe, fd, pd, oe;
  logic            an_en = 1'h0, an_fd = 1'h0, an_st, an_rs, pin_n = 1'h1, oe_e;
  logic [4:0]      addr = 5'h00;
  logic [3:0]      dly = 4'h1;
  logic [15:0]     wd = 16'h0000, rdat, m;
  logic [31:0]     seed = 32'h63856339, r;
  pbmc_mii_tx_type tx = 6'h00, ctx;
  pbmc_mii_rx_type crx = 8'h00, rx;
  int              n_fail = 0, cmp_count = 0;
  logic            q[$];
  pbmc_top uut (.ref_clk_i(clk), .resetn_i(rst_n), .mgmt_addr_i(addr), .mgmt_wr_i(wr),
    .mgmt_rd_i(rd), .mgmt_wdata_i(wd), .mgmt_rdata_o(rdat), .mgmt_rvalid_o(rv),
    .an_enable_i(an_en), .an_full_duplex_i(an_fd), .an_started_i(an_st),
    .duplex_strap_i(1'h1), .power_down_interrupt_pin_n_i(pin_n), .an_restart_o(an_rs),
    .power_down_o(pd), .func_enable_o(fe), .full_duplex_o(fd), .mii_tx_i(tx),
    .mii_rx_o(rx), .mii_rx_oe_o(oe), .core_rx_i(crx), .core_tx_o(ctx));
  pbmc_an_model eng (.ref_clk_i(clk), .resetn_i(rst_n), .an_restart_i(an_rs),
    .delay_i(dly), .an_started_o(an_st));
  initial forever #12.5 clk = ~clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic wrt(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  // read answers on the edge that takes the strobe, seen 1 ns after it
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    `CHK(rv, 1'h1)
    `CHK(rdat, e)
  endtask
  // bounded wait for the engine to clear the request
  task automatic rs_low();
    for (int k = 0; k < 40 && an_rs !== 1'h0; k++) @(posedge clk);
    `CHK(an_rs, 1'h0)
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    rdc(5'h00, 16'h0100);
    // random control words; restart masked so the model needs no engine timing
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      r = xs();
      an_en <= r[16];
      an_fd <= r[17];
      tx <= r[23:18];
      crx <= {r[31:25], 1'h0};
      wrt(5'h00, r[15:0] & 16'hfdff);
      m = r[15:0] & 16'h0d80;
      oe_e = !(m[11] | m[10]);
      rdc(5'h00, m);
      `CHK(oe, oe_e)
      `CHK(pd, m[11])
      `CHK(fe, !m[11])
      `CHK(fd, an_en ? an_fd : m[8])
      `CHK(ctx, oe_e ? tx : 6'h00)
      `CHK(rx, oe_e ? (crx | {7'h00, m[7] & tx.tx_en}) : 8'h00)
    end
    wrt(5'h03, 16'h0c00);
    rdc(5'h00, m);
    rdc(5'h03, 16'h0000);
    $display("test random and unmapped done");
    @(posedge clk);
    an_en <= 1'h1;
    dly <= 4'hc;
    wrt(5'h00, 16'h0200);
    rdc(5'h00, 16'h0200);
    wrt(5'h00, 16'h0000);
    rdc(5'h00, 16'h0000);
    `CHK(an_rs, 1'h1)
    rs_low();
    rdc(5'h00, 16'h0000);
    @(posedge clk);
    dly <= 4'h1;
    wrt(5'h00, 16'h0200);
    rs_low();
    @(posedge clk);
    an_en <= 1'h0;
    wrt(5'h00, 16'h0200);
    rdc(5'h00, 16'h0000);
    `CHK(an_rs, 1'h0)
    $display("test restart done");
    @(posedge clk);
    pin_n <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
    `CHK(pd, 1'h1)
    `CHK(fe, 1'h0)
    rdc(5'h00, 16'h0800);
    @(posedge clk);
    pin_n <= 1'h1;
    repeat (3) @(posedge clk);
    wrt(5'h00, 16'h0000);
    rdc(5'h00, 16'h0000);
    $display("test power down done");
    // random tx_en pulses; col must follow three edges later
    wrt(5'h00, 16'h0080);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 48; i++) begin
      @(posedge clk);
      r = xs();
      tx.tx_en <= r[0];
      q.push_back(r[0]);
      #1;
      if (q.size() > 3) `CHK(rx.col, q.pop_front())
    end
    $display("test collision done");
    print_verdict();
  end
endmodule
bind pbmc_top pbmc_checker chk (.ref_clk_i, .resetn_i, .mgmt_addr_i, .mgmt_wr_i,
  .mgmt_wdata_i, .an_enable_i, .an_full_duplex_i, .an_started_i,
  .power_down_interrupt_pin_n_i, .an_restart_o, .power_down_o, .full_duplex_o,
  .mii_tx_i, .mii_rx_o, .mii_rx_oe_o);
